// *** verilog/dram3_pkg.sv ***
// Package for the three-phase dynamic RAM model: geometry, pin groups.
// Assumes the clock phases arrive active low from an outside controller.
package dram3_pkg;
    localparam int COL_BITS = 5;
    localparam int ROW_BITS = 6;
    localparam int ADDR_BITS = COL_BITS + ROW_BITS;
    localparam int NUM_COLS = 32;
    localparam int NUM_ROWS = 64;
    localparam logic RESET_DOUT = 1'h0;
    localparam logic RESET_INV = 1'h0;

    // Three clock phases, active low, as seen on the pins
    typedef struct packed {
        logic ph1_n;
        logic ph2_n;
        logic ph3_n;
    } phases_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRE = 2'b01,
        ST_SENSE = 2'b10,
        ST_WRITE = 2'b11
    } cyc_state_t;
endpackage : dram3_pkg

// *** verilog/dram3_column.sv ***
// One memory column: a row of three-device cells plus its inversion bit.
// Assumes strobes are single-cycle pulses from the sequencer on mclk.
`timescale 1ns/1ps
module dram3_column
    import dram3_pkg::*;
#(
    parameter int ROWS = NUM_ROWS
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Controls from sequencer
    input wire logic [ROWS-1:0] row_sel,
    input wire logic col_sel,
    input wire logic write_stb,
    input wire logic refresh_stb,
    input wire logic bit_line,
    // Sensed values
    output logic sense_out,
    output logic inv_out
);
    logic [ROWS-1:0] cell_q;
    logic inv_q;

    // Read select device gates the complemented storage onto the bit line
    assign sense_out = ~|(cell_q & row_sel);
    assign inv_out = inv_q;

    // Refresh rewrites every row of the column from its inverted sense
    genvar r;
    generate
        for (r = 0; r < ROWS; r++)
        begin : g_cell
            always_ff @(posedge mclk)
            begin
                if (col_sel && refresh_stb)
                begin
                    cell_q[r] <= ~cell_q[r];
                end
                else if (col_sel && write_stb && row_sel[r])
                begin
                    cell_q[r] <= bit_line;
                end
            end
        end
    endgenerate

    // Inversion bit tracks stored polarity, so it alone needs reset
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            inv_q <= RESET_INV;
        end
        else if (col_sel && refresh_stb)
        begin
            inv_q <= ~inv_q;
        end
    end
endmodule : dram3_column

// *** verilog/dram3_core.sv ***
// Top of the three-phase dynamic RAM: phase sequencing, decode, data path.
// Assumes an outside controller drives phases, address and data pins.
`timescale 1ns/1ps
module dram3_core
    import dram3_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Pins from the controller
    input wire dram3_pkg::phases_t phases,
    input wire logic [dram3_pkg::ADDR_BITS-1:0] addr,
    input wire logic din,
    input wire logic write_en,
    // Data out
    output logic dout,
    output dram3_pkg::cyc_state_t cyc_state
);
    import dram3_pkg::*;

    // ====================
    // Pin synchronisers
    phases_t ph_m, ph_s, ph_p;
    logic [ADDR_BITS-1:0] addr_m, addr_s;
    logic din_m, din_s, we_m, we_s;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ph_m <= 3'h7;
            ph_s <= 3'h7;
            ph_p <= 3'h7;
        end
        else
        begin
            ph_m <= phases;
            ph_s <= ph_m;
            ph_p <= ph_s;
        end
    end

    always_ff @(posedge mclk)
    begin
        addr_m <= addr;
        addr_s <= addr_m;
        din_m <= din;
        din_s <= din_m;
        we_m <= write_en;
        we_s <= we_m;
    end

    logic ph1_fall, ph1_rise, ph2_fall, ph3_fall, ph3_rise;
    assign ph1_fall = ph_p.ph1_n && !ph_s.ph1_n;
    assign ph1_rise = !ph_p.ph1_n && ph_s.ph1_n;
    assign ph2_fall = ph_p.ph2_n && !ph_s.ph2_n;
    assign ph3_fall = ph_p.ph3_n && !ph_s.ph3_n;
    assign ph3_rise = !ph_p.ph3_n && ph_s.ph3_n;

    // ====================
    // Cycle sequencer
    cyc_state_t state_q;
    logic [ADDR_BITS-1:0] addr_q;
    logic wr_q;
    assign cyc_state = state_q;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
        end
        else if (ph1_fall)
        begin
            state_q <= ST_PRE;
        end
        else
        begin
            case (state_q)
                ST_PRE:
                begin
                    if (ph2_fall)
                    begin
                        state_q <= ST_SENSE;
                    end
                end
                ST_SENSE:
                begin
                    // Without phase3 the cycle just ends here
                    if (ph3_fall)
                    begin
                        state_q <= ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    if (ph3_rise)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // Address latched as phase1 ends, when it must be stable
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            addr_q <= '0;
            wr_q <= 1'h0;
        end
        else if (ph1_rise && state_q == ST_PRE)
        begin
            addr_q <= addr_s;
            wr_q <= we_s;
        end
    end

    // ====================
    // Decoders
    logic [COL_BITS-1:0] col_idx;
    logic [ROW_BITS-1:0] row_idx;
    logic [NUM_ROWS-1:0] row_sel;
    logic [NUM_COLS-1:0] col_sel;
    assign col_idx = addr_q[COL_BITS-1:0];
    assign row_idx = addr_q[ADDR_BITS-1:COL_BITS];
    assign row_sel = NUM_ROWS'(1) << row_idx;
    assign col_sel = NUM_COLS'(1) << col_idx;

    // ====================
    // Columns and data path
    logic [NUM_COLS-1:0] sense_v, inv_v;
    logic write_stb, refresh_stb, bit_line, cell_now, inv_now;
    assign write_stb = ph3_fall && state_q == ST_SENSE && wr_q;
    assign refresh_stb = ph3_fall && state_q == ST_SENSE && !wr_q;
    assign inv_now = inv_v[col_idx];
    assign cell_now = ~sense_v[col_idx];
    assign bit_line = din_s ^ inv_now;

    genvar c;
    generate
        for (c = 0; c < NUM_COLS; c++)
        begin : g_col
            dram3_column #(
                .ROWS(NUM_ROWS)
            ) u_col (
                .mclk(mclk),
                .rst(rst),
                .row_sel(row_sel),
                .col_sel(col_sel[c]),
                .write_stb(write_stb),
                .refresh_stb(refresh_stb),
                .bit_line(bit_line),
                .sense_out(sense_v[c]),
                .inv_out(inv_v[c])
            );
        end
    endgenerate

    // Output register: cleared at phase1, loaded at phase2 sense
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dout <= RESET_DOUT;
        end
        else if (ph2_fall && state_q == ST_PRE)
        begin
            dout <= cell_now ^ inv_now;
        end
        else if (ph1_fall)
        begin
            dout <= RESET_DOUT;
        end
    end
endmodule : dram3_core

// *** verif/dram3_core_sva.sv ***
// Checker for the three-phase RAM top: phase sequencing and output hold.
// Assumes it is bound to dram3_core; pin phases pass a 3 mclk synchroniser.
`timescale 1ns/1ps
module dram3_core_sva
    import dram3_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Watched ports
    input wire dram3_pkg::phases_t phases,
    input wire logic dout,
    input wire dram3_pkg::cyc_state_t cyc_state
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ========
    // Sequencing
    a_pre_entry: assert property ($fell(phases.ph1_n) |-> ##3 cyc_state == ST_PRE)
        else $error("no precharge after phase one");
    a_pre_clear: assert property (cyc_state == ST_PRE |-> dout == 1'h0)
        else $error("dout not cleared in precharge");
    a_sense_entry: assert property ($fell(phases.ph2_n) && cyc_state == ST_PRE
        |-> ##3 cyc_state == ST_SENSE) else $error("no sense after phase two");
    a_sense_order: assert property (cyc_state == ST_SENSE && $past(cyc_state) != ST_SENSE
        |-> $past(cyc_state) == ST_PRE) else $error("sense without precharge");
    a_write_entry: assert property ($fell(phases.ph3_n) && cyc_state == ST_SENSE
        |-> ##3 cyc_state == ST_WRITE) else $error("no write after phase three");
    a_write_order: assert property (cyc_state == ST_WRITE && $past(cyc_state) != ST_WRITE
        |-> $past(cyc_state) == ST_SENSE) else $error("write without sense");
    a_write_exit: assert property ($rose(phases.ph3_n) && cyc_state == ST_WRITE
        |-> ##3 cyc_state == ST_IDLE) else $error("write not closed");
    // Output may move only when a cycle starts or sensing begins
    a_dout_hold: assert property (!$past(rst) && !(cyc_state != $past(cyc_state)
        && cyc_state inside {ST_PRE, ST_SENSE}) |-> $stable(dout))
        else $error("dout changed between cycles");
endmodule : dram3_core_sva

// *** verif/dram3_ctrl.sv ***
// Controller model: sequences the three phases, address and data.
// Assumes the bench calls run; pins change on falling mclk.
`timescale 1ns/1ps
module dram3_ctrl
    import dram3_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Device pins
    output dram3_pkg::phases_t phases,
    output logic [dram3_pkg::ADDR_BITS-1:0] addr,
    output logic din,
    output logic write_en
);
    initial
    begin
        phases = '1;
        addr = '0;
        din = 1'h0;
        write_en = 1'h0;
    end
    // ========
    // One phase: 6 mclk low, 6 high, well over the 20ns gap
    task automatic pulse(input int p);
        phases[p] <= 1'h0;
        repeat (6) @(negedge mclk);
        phases[p] <= 1'h1;
        repeat (6) @(negedge mclk);
    endtask : pulse
    // Kind 0 read, 1 write, 2 refresh
    task automatic run(input logic [1:0] k, input logic [10:0] a, input logic d);
        @(negedge mclk);
        addr <= a;
        din <= d;
        write_en <= (k == 2'h1);
        pulse(2);
        pulse(1);
        if (k != 2'h0)
            pulse(0);
        // Released address and data pins show the inverse; write_en keeps its value
        addr <= ~a;
        din <= ~d;
    endtask : run
endmodule : dram3_ctrl

// *** verif/dram3_core_bench.sv ***
// Self-checking bench for the three-phase RAM top.
// Assumes the controller model and checker are compiled before it.
`timescale 1ns/1ps
module dram3_core_bench;
    import dram3_pkg::*;
    localparam logic [1:0] RD = 2'h0;
    localparam logic [1:0] WR = 2'h1;
    localparam logic [1:0] RF = 2'h2;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    phases_t phases;
    logic [ADDR_BITS-1:0] addr;
    logic din;
    logic write_en;
    logic dout;
    cyc_state_t cyc_state;
    int fail_count = 0;
    int checks = 0;
    always #5 mclk = ~mclk;
    dram3_ctrl dram3_ctrl_i (.mclk(mclk), .phases(phases), .addr(addr), .din(din),
        .write_en(write_en));
    dram3_core dram3_core_i (.mclk(mclk), .rst(rst), .phases(phases), .addr(addr),
        .din(din), .write_en(write_en), .dout(dout), .cyc_state(cyc_state));
    // ========
    // Helpers
    task automatic finish_test;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic read_check(input logic [10:0] a, input logic e);
        dram3_ctrl_i.run(RD, a, ~e);
        checks++;
        if (dout !== e)
            $display("BAD t=%0t dout=%h exp=%h", $time, dout, e);
        if (dout !== e)
            fail_count++;
    endtask : read_check
    // ========
    // Scenarios
    task automatic t_write_read;
        logic [10:0] a [4] = '{11'h000, 11'h7FF, 11'h021, 11'h001};
        logic d [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
        for (int i = 0; i < 4; i++)
            dram3_ctrl_i.run(WR, a[i], d[i]);
        for (int i = 0; i < 4; i++)
            read_check(a[i], d[i]);
    endtask : t_write_read
    task automatic t_refresh;
        dram3_ctrl_i.run(RF, 11'h001, 1'h1);
        read_check(11'h021, 1'h1);
        read_check(11'h001, 1'h0);
        dram3_ctrl_i.run(WR, 11'h001, 1'h1);
        read_check(11'h001, 1'h1);
        for (int c = 0; c < NUM_COLS; c++)
            dram3_ctrl_i.run(RF, 11'(c), 1'h0);
        read_check(11'h7FF, 1'h0);
        read_check(11'h021, 1'h1);
    endtask : t_refresh
    task automatic t_hold;
        read_check(11'h000, 1'h1);
        repeat (20) @(negedge mclk);
        checks++;
        if (dout !== 1'h1)
            $display("BAD t=%0t dout=%h exp=%h", $time, dout, 1'h1);
        if (dout !== 1'h1)
            fail_count++;
    endtask : t_hold
    initial
    begin
        repeat (12) @(negedge mclk);
        rst = 1'h0;
        t_write_read();
        t_refresh();
        t_hold();
        finish_test();
    end
endmodule : dram3_core_bench
bind dram3_core dram3_core_sva dram3_core_sva_i (.mclk(mclk), .rst(rst), .phases(phases),
    .dout(dout), .cyc_state(cyc_state));
